// ### demand_curve_pkg.sv
// constants shared by the demand curve transformer
package demand_curve_pkg;
    localparam int DEMAND_W = 9;
    localparam int POINT_W = 18;
    localparam int NVM_AW = 6;
    localparam int CURVE_POINTS = 32;
    localparam logic [5:0] CURVE_BASE = 6'h20;
    localparam logic [5:0] CURVE_LAST = 6'h3f;
    localparam int POINT_X_LSB = 9;
    localparam int POINT_Y_LSB = 0;
    localparam logic [8:0] DEMAND_MAX = 9'h1ff;
    localparam logic [8:0] STOP_UNI = 9'h000;
    localparam logic [8:0] STOP_BIDIR = 9'h0ff;
    localparam logic [8:0] OUT_RESET = 9'h000;
    localparam logic [5:0] SEG_NONE = 6'h3f;
    localparam int DIV_STEPS = 18;
    localparam logic [4:0] DIV_LAST = 5'h11;
    localparam int UPDATE_MAX_CYCLES = 2 * CURVE_POINTS + DIV_STEPS + 4;
    localparam logic [1:0] MODE_SPEED = 2'h0;
    localparam logic [1:0] MODE_TORQUE = 2'h1;
    localparam logic [1:0] MODE_POWER = 2'h2;
    localparam logic [1:0] MODE_OPEN_LOOP = 2'h3;
endpackage

// ### demand_curve_transformer.sv
// piecewise-linear demand curve transformer with hysteresis and bidirectional option
//
// Behaviour
// R1: a 9-bit input demand 0..511 maps to a 9-bit output demand through the curve.
// R2: corner points are read from nonvolatile locations 32 to 63, one point per location.
// R3: the curve applies in speed, torque, power and open-loop modes, and the mode travels with the output.
// R4: in open-loop mode the output is a duty command, 511 meaning full motor_supply_voltage.
// R5: in closed-loop modes 511 stands for the configured loop maximum, scaled linearly downstream.
// R6: each point word holds the input demand in its upper nine bits and the output in its lower nine.
// R7: inputs between corners get the linear interpolation of the two neighbouring corners.
// R8: the configurer ends the curve with input 511 and every later location is ignored.
// R9: at most 32 corner points are used, and only those up to the terminator need programming.
// R10: with the transformer disabled the input passes unchanged to the output.
// R11: a corner below its predecessor gives hysteresis, rising steps up late and falling steps down late.
// R12: with bidirectional selected, 255 is stop, 511 full forward and 0 full reverse.
// R13: points are read straight from nonvolatile memory on each update, with no shadow copy.
// R14: zero-demand detection looks at the transformed output, not the raw input.
// R15: the last used segment is kept as state and interpolated results are truncated to 0..511.
// R16: any change of input recomputes the output, which is stable within a bounded number of cycles.
`timescale 1ns/100ps
module demand_curve_transformer #(
    parameter int POINTS = demand_curve_pkg::CURVE_POINTS
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [8:0] demand_in,
    input wire logic xform_en,
    input wire logic bidir_en,
    input wire logic [1:0] ctrl_mode,
    output logic [5:0] nvm_addr,
    input wire logic [17:0] nvm_data,
    output logic [8:0] demand_out,
    output logic [1:0] demand_kind,
    output logic duty_cmd,
    output logic dir_reverse,
    output logic zero_demand,
    output logic out_valid
);
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_READ, S_PREP, S_DIV, S_DONE} state_e;

    // output code that means the motor is stopped
    function automatic logic [8:0] stop_code(input logic bidir);
        return bidir ? demand_curve_pkg::STOP_BIDIR : demand_curve_pkg::STOP_UNI;
    endfunction

    state_e state, next_state;
    logic [8:0] samp, next_samp, prev_x, next_prev_x, prev_y, next_prev_y;
    logic [8:0] sel_x0, next_sel_x0, sel_x1, next_sel_x1, sel_y0, next_sel_y0, sel_y1, next_sel_y1;
    logic [8:0] rem, next_rem, next_demand_out;
    logic [5:0] sel_idx, next_sel_idx, last_seg, next_last_seg, next_nvm_addr;
    logic [4:0] idx, next_idx, cnt, next_cnt;
    logic [17:0] num, next_num;
    logic [1:0] next_demand_kind;
    logic en_s, next_en_s, started, next_started, rising, next_rising, have_prev, next_have_prev;
    logic have_sel, next_have_sel, locked, next_locked, neg, next_neg;
    logic next_duty_cmd, next_dir_reverse, next_zero_demand, next_out_valid;

    // corner word fields
    logic [8:0] pt_x, pt_y;
    assign pt_x = nvm_data[demand_curve_pkg::POINT_X_LSB +: 9]; // R6
    assign pt_y = nvm_data[demand_curve_pkg::POINT_Y_LSB +: 9]; // R6

    // scan, select segment, divide, publish
    always_comb begin
        logic hit, take;
        logic [9:0] trial;
        logic [10:0] sum;
        logic [8:0] val, mag;
        hit = 1'b0;
        take = 1'b0;
        trial = 10'h000;
        sum = 11'h000;
        val = 9'h000;
        mag = 9'h000;
        next_state = state;
        {next_samp, next_prev_x, next_prev_y, next_rem} = {samp, prev_x, prev_y, rem};
        {next_sel_x0, next_sel_x1, next_sel_y0, next_sel_y1} = {sel_x0, sel_x1, sel_y0, sel_y1};
        {next_en_s, next_started, next_rising, next_have_prev} = {en_s, started, rising, have_prev};
        {next_have_sel, next_locked, next_neg, next_num} = {have_sel, locked, neg, num};
        {next_idx, next_cnt, next_sel_idx, next_last_seg} = {idx, cnt, sel_idx, last_seg};
        {next_nvm_addr, next_demand_out, next_demand_kind} = {nvm_addr, demand_out, demand_kind};
        {next_duty_cmd, next_dir_reverse} = {duty_cmd, dir_reverse};
        {next_zero_demand, next_out_valid} = {zero_demand, out_valid};
        unique case (state)
            S_IDLE: begin
                // a demand or enable change restarts the pass; mode or direction changes only republish
                if (!started || demand_in != samp || xform_en != en_s) begin // R16
                    next_samp = demand_in;
                    next_en_s = xform_en;
                    next_rising = demand_in >= samp;
                    next_started = 1'b1;
                    next_out_valid = 1'b0;
                    next_idx = 5'h00;
                    next_have_prev = 1'b0;
                    next_have_sel = 1'b0;
                    next_locked = 1'b0;
                    next_nvm_addr = demand_curve_pkg::CURVE_BASE; // R2 R13
                    next_state = xform_en ? S_ADDR : S_DONE; // R10
                end else if (ctrl_mode != demand_kind || zero_demand != (demand_out == stop_code(bidir_en))
                    || dir_reverse != (bidir_en && demand_out < demand_curve_pkg::STOP_BIDIR)) begin // R12 R14
                    next_state = S_DONE;
                end
            end
            S_ADDR: begin
                // memory returns the word one cycle after the address
                next_state = S_READ; // R13
            end
            S_READ: begin
                // only ascending pairs form segments; a step back only opens hysteresis
                hit = have_prev && pt_x > prev_x && samp >= prev_x && samp <= pt_x; // R7 R11
                take = hit && !locked && ({1'b0, idx} == last_seg || !rising || !have_sel); // R11 R15
                if (!have_prev) begin
                    // flat fallback for inputs below the first corner
                    next_sel_x0 = 9'h000;
                    next_sel_x1 = 9'h001;
                    next_sel_y0 = pt_y;
                    next_sel_y1 = pt_y;
                end
                if (take) begin
                    next_sel_x0 = prev_x;
                    next_sel_x1 = pt_x;
                    next_sel_y0 = prev_y;
                    next_sel_y1 = pt_y;
                    next_sel_idx = {1'b0, idx};
                    next_have_sel = 1'b1;
                    next_locked = {1'b0, idx} == last_seg;
                end
                next_prev_x = pt_x;
                next_prev_y = pt_y;
                next_have_prev = 1'b1;
                if (pt_x == demand_curve_pkg::DEMAND_MAX || idx == 5'(POINTS - 1)) begin // R8 R9
                    next_state = S_PREP;
                end else begin
                    next_idx = idx + 5'h01;
                    next_nvm_addr = demand_curve_pkg::CURVE_BASE + {1'b0, next_idx}; // R2
                    next_state = S_ADDR;
                end
            end
            S_PREP: begin
                next_neg = sel_y1 < sel_y0;
                mag = next_neg ? sel_y0 - sel_y1 : sel_y1 - sel_y0;
                next_num = 18'(mag) * 18'(samp - sel_x0); // R7
                next_rem = 9'h000;
                next_cnt = 5'h00;
                next_state = S_DIV;
            end
            S_DIV: begin
                // restoring divide, one quotient bit per cycle to keep the area small
                trial = {rem, num[17]};
                if (trial >= {1'b0, sel_x1 - sel_x0}) begin
                    next_rem = 9'(trial - {1'b0, sel_x1 - sel_x0});
                    next_num = {num[16:0], 1'b1};
                end else begin
                    next_rem = trial[8:0];
                    next_num = {num[16:0], 1'b0};
                end
                next_cnt = cnt + 5'h01;
                if (cnt == demand_curve_pkg::DIV_LAST) begin
                    next_state = S_DONE;
                end
            end
            S_DONE: begin
                if (en_s) begin
                    // quotient already truncated; clamp guards a corrupt curve
                    sum = neg ? {2'b00, sel_y0} - 11'(num) : {2'b00, sel_y0} + 11'(num); // R15
                    val = sum[10] ? 9'h000 : (sum[9] ? demand_curve_pkg::DEMAND_MAX : sum[8:0]); // R1 R15
                    next_last_seg = have_sel ? sel_idx : demand_curve_pkg::SEG_NONE; // R15
                end else begin
                    val = samp; // R10
                    next_last_seg = demand_curve_pkg::SEG_NONE;
                end
                next_demand_out = val;
                next_demand_kind = ctrl_mode; // R3 R5
                next_duty_cmd = ctrl_mode == demand_curve_pkg::MODE_OPEN_LOOP; // R4
                next_dir_reverse = bidir_en && val < demand_curve_pkg::STOP_BIDIR; // R12
                next_zero_demand = val == stop_code(bidir_en); // R14
                next_out_valid = 1'b1; // R16
                next_state = S_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            {samp, prev_x, prev_y} <= 27'h0000000;
            {sel_x0, sel_y0, sel_y1, rem} <= 36'h000000000;
            sel_x1 <= 9'h001;
            {en_s, started, have_prev, have_sel, locked, neg} <= 6'h00;
            rising <= 1'b1;
            {idx, cnt} <= 10'h000;
            {sel_idx, last_seg} <= {demand_curve_pkg::SEG_NONE, demand_curve_pkg::SEG_NONE};
            num <= 18'h00000;
            nvm_addr <= demand_curve_pkg::CURVE_BASE;
            demand_out <= demand_curve_pkg::OUT_RESET;
            demand_kind <= demand_curve_pkg::MODE_SPEED;
            {duty_cmd, dir_reverse, out_valid} <= 3'h0;
            zero_demand <= 1'b1;
        end else begin
            state <= next_state;
            {samp, prev_x, prev_y, rem} <= {next_samp, next_prev_x, next_prev_y, next_rem};
            {sel_x0, sel_x1, sel_y0, sel_y1} <= {next_sel_x0, next_sel_x1, next_sel_y0, next_sel_y1};
            {en_s, started, rising, have_prev} <= {next_en_s, next_started, next_rising, next_have_prev};
            {have_sel, locked, neg, num} <= {next_have_sel, next_locked, next_neg, next_num};
            {idx, cnt, sel_idx, last_seg} <= {next_idx, next_cnt, next_sel_idx, next_last_seg};
            {nvm_addr, demand_out, demand_kind} <= {next_nvm_addr, next_demand_out, next_demand_kind};
            {duty_cmd, dir_reverse} <= {next_duty_cmd, next_dir_reverse};
            {zero_demand, out_valid} <= {next_zero_demand, next_out_valid};
        end
    end

    // checks
    sequence s_last_point;
        state == S_READ && pt_x == demand_curve_pkg::DEMAND_MAX;
    endsequence
    sequence s_scan_over;
        state == S_PREP ##1 state == S_DIV;
    endsequence

    property p_addr_window;
        @(posedge clk_sys) disable iff (rst)
        state == S_READ |-> nvm_addr >= demand_curve_pkg::CURVE_BASE && nvm_addr <= demand_curve_pkg::CURVE_LAST;
    endproperty
    a_addr_window: assert property (p_addr_window) else $error("curve address out of window"); // R2

    property p_read_latency;
        @(posedge clk_sys) disable iff (rst)
        state == S_READ |-> $past(state) == S_ADDR && $stable(nvm_addr);
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("point read without address cycle"); // R13

    property p_terminator;
        @(posedge clk_sys) disable iff (rst)
        s_last_point |=> s_scan_over;
    endproperty
    a_terminator: assert property (p_terminator) else $error("scan continued past terminator"); // R8

    property p_point_limit;
        @(posedge clk_sys) disable iff (rst)
        state == S_READ && idx == 5'h1f |=> state == S_PREP;
    endproperty
    a_point_limit: assert property (p_point_limit) else $error("more than 32 points read"); // R9

    property p_identity;
        @(posedge clk_sys) disable iff (rst)
        state == S_DONE && !en_s |=> out_valid && demand_out == $past(samp);
    endproperty
    a_identity: assert property (p_identity) else $error("disabled output differs from input"); // R10

    property p_bounded_update;
        @(posedge clk_sys) disable iff (rst)
        state == S_IDLE && started && demand_in != samp |=> !out_valid ##[1:90] out_valid;
    endproperty
    a_bounded_update: assert property (p_bounded_update) else $error("output not updated in time"); // R16

    property p_interp_range;
        @(posedge clk_sys) disable iff (rst)
        state == S_DONE && en_s |=> demand_out >= ($past(neg) ? $past(sel_y1) : $past(sel_y0))
            && demand_out <= ($past(neg) ? $past(sel_y0) : $past(sel_y1));
    endproperty
    a_interp_range: assert property (p_interp_range) else $error("interpolation outside segment"); // R7

    property p_zero_flag;
        @(posedge clk_sys) disable iff (rst)
        out_valid && bidir_en == $past(bidir_en) && bidir_en == $past(bidir_en, 2)
            |-> zero_demand == (demand_out == stop_code(bidir_en));
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero demand flag wrong"); // R14

    property p_bidir_dir;
        @(posedge clk_sys) disable iff (rst)
        out_valid && bidir_en && $past(bidir_en) && $past(bidir_en, 2)
            |-> dir_reverse == (demand_out < demand_curve_pkg::STOP_BIDIR);
    endproperty
    a_bidir_dir: assert property (p_bidir_dir) else $error("direction flag wrong"); // R12

    property p_duty_mode;
        @(posedge clk_sys) disable iff (rst)
        state == S_DONE |=> duty_cmd == ($past(ctrl_mode) == demand_curve_pkg::MODE_OPEN_LOOP)
            && demand_kind == $past(ctrl_mode);
    endproperty
    a_duty_mode: assert property (p_duty_mode) else $error("duty flag does not follow mode"); // R4
endmodule

// ### demand_curve_transformer_tb.sv
// self-checking bench for the demand curve transformer
`timescale 1ns/100ps
module demand_curve_transformer_tb;
    logic clk_sys, rst, xform_en, bidir_en, duty_cmd, dir_reverse, zero_demand, out_valid;
    logic [8:0] demand_in, demand_out, prev_in, r;
    logic [1:0] ctrl_mode, demand_kind;
    logic [5:0] nvm_addr;
    logic [17:0] nvm_data;
    logic [15:0] seed;
    logic [8:0] px [0:31];
    logic [8:0] py [0:31];
    logic [8:0] hv [0:4] = '{9'h064, 9'h0fa, 9'h15e, 9'h0fa, 9'h096};
    int npts, last_seg, failures, samples_checked;

    demand_curve_transformer dut_u (.clk_sys(clk_sys), .rst(rst), .demand_in(demand_in), .xform_en(xform_en),
        .bidir_en(bidir_en), .ctrl_mode(ctrl_mode), .nvm_addr(nvm_addr), .nvm_data(nvm_data),
        .demand_out(demand_out), .demand_kind(demand_kind), .duty_cmd(duty_cmd), .dir_reverse(dir_reverse),
        .zero_demand(zero_demand), .out_valid(out_valid));

    nvm_model nvm_u (.clk_sys(clk_sys), .nvm_addr(nvm_addr), .nvm_data(nvm_data));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // fibonacci lfsr, taps 16 14 13 11
    function automatic logic [8:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[8:0];
    endfunction

    // descending corner pairs make no segment, they only open a hysteresis gap
    function automatic bit covers(int i, logic [8:0] v);
        return i < npts - 1 && px[i+1] > px[i] && v >= px[i] && v <= px[i+1];
    endfunction

    // reference walk; keeps the last segment like the design so overlaps resolve by direction
    function automatic logic [8:0] curve_out(logic [8:0] v);
        int seg;
        int y;
        bit up;
        seg = -1;
        up = v >= prev_in;
        if (last_seg >= 0 && covers(last_seg, v)) begin
            seg = last_seg;
        end else begin
            for (int i = 0; i < npts; i++) begin
                if (covers(i, v) && (seg < 0 || !up)) seg = i;
            end
        end
        last_seg = seg;
        if (seg < 0) return py[0];
        y = int'(py[seg]) + (int'(py[seg+1]) - int'(py[seg])) * (int'(v) - int'(px[seg]))
            / (int'(px[seg+1]) - int'(px[seg]));
        return (y < 0) ? 9'h000 : (y > 511) ? 9'h1ff : 9'(y);
    endfunction

    task automatic check(logic [8:0] seen, logic [8:0] exp, string what);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // fill every word with a stray point, then the corners; strays past the end must not count
    task automatic load(int n);
        for (int i = 0; i < 64; i++) nvm_u.mem[i] = {9'h0a5, 9'h00b};
        for (int i = 0; i < n; i++) nvm_u.mem[6'h20 + i] = {px[i], py[i]};
        npts = n;
        last_seg = -1;
    endtask

    // drive at the falling edge, then wait for the republished result under a bound
    task automatic apply(logic [8:0] v, logic en, logic bi, logic [1:0] md);
        int n;
        logic [8:0] exp;
        @(negedge clk_sys);
        demand_in = v;
        xform_en = en;
        bidir_en = bi;
        ctrl_mode = md;
        exp = en ? curve_out(v) : v;
        prev_in = v;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        n = 0;
        while (out_valid !== 1'b1 && n < demand_curve_pkg::UPDATE_MAX_CYCLES) begin
            @(negedge clk_sys);
            n++;
        end
        check(9'(out_valid), 9'h001, "settle");
        check(demand_out, exp, "demand");
        check(9'(zero_demand), 9'(exp == (bi ? 9'h0ff : 9'h000)), "zero flag");
        check(9'(dir_reverse), 9'(bi && exp < 9'h0ff), "reverse flag");
        check(9'(demand_kind), 9'(md), "kind");
        check(9'(duty_cmd), 9'(md == demand_curve_pkg::MODE_OPEN_LOOP), "duty");
    endtask

    initial begin
        rst = 1'b1;
        demand_in = 9'h000;
        xform_en = 1'b0;
        bidir_en = 1'b0;
        ctrl_mode = 2'h0;
        seed = 16'h002b;
        prev_in = 9'h000;
        failures = 0;
        samples_checked = 0;
        px[0] = 9'h000;
        py[0] = 9'h190;
        px[1] = 9'h100;
        py[1] = 9'h032;
        px[2] = 9'h1ff;
        py[2] = 9'h1ff;
        load(3);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        // identity path with stop-code corners in both readings
        apply(9'h0ff, 1'b0, 1'b1, demand_curve_pkg::MODE_OPEN_LOOP);
        apply(9'h000, 1'b0, 1'b0, demand_curve_pkg::MODE_SPEED);
        apply(9'h1ff, 1'b0, 1'b1, demand_curve_pkg::MODE_TORQUE);
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            apply(r, 1'b0, seed[9], seed[11:10]);
        end
        $display("identity test done");
        // falling then rising three-corner curve, shared corner and both ends
        apply(9'h000, 1'b1, 1'b0, demand_curve_pkg::MODE_SPEED);
        apply(9'h100, 1'b1, 1'b1, demand_curve_pkg::MODE_POWER);
        apply(9'h1ff, 1'b1, 1'b0, demand_curve_pkg::MODE_OPEN_LOOP);
        for (int i = 0; i < 20; i++) begin
            r = rnd();
            apply(r, 1'b1, seed[9], seed[11:10]);
        end
        $display("three point test done");
        // full 32 corners, rewritten in place without any reload command
        for (int i = 0; i < 31; i++) begin
            px[i] = 9'(i * 16);
            py[i] = rnd();
        end
        px[31] = 9'h1ff;
        py[31] = rnd();
        load(32);
        apply(9'h1ff, 1'b1, 1'b0, demand_curve_pkg::MODE_SPEED);
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            apply(r, 1'b1, seed[9], seed[11:10]);
        end
        $display("full curve test done");
        // overlapping segments: up late, down late
        px[0] = 9'h000;
        py[0] = 9'h000;
        px[1] = 9'h12c;
        py[1] = 9'h000;
        px[2] = 9'h0c8;
        py[2] = 9'h1ff;
        px[3] = 9'h1ff;
        py[3] = 9'h1ff;
        load(4);
        for (int i = 0; i < 5; i++) apply(hv[i], 1'b1, 1'b0, demand_curve_pkg::MODE_SPEED);
        $display("hysteresis test done");
        close_out();
    end

    // bound well above the expected run of a few thousand cycles
    initial begin
        #500000;
        failures++;
        close_out();
    end
endmodule

// ### nvm_model.sv
// synchronous-read curve memory standing in front of the transformer
`timescale 1ns/100ps
module nvm_model (
    input wire logic clk_sys,
    input wire logic [5:0] nvm_addr,
    output logic [17:0] nvm_data
);
    logic [17:0] mem [0:63];

    // one-cycle read latency; no shadow copy, so an edit shows on the next pass
    always_ff @(posedge clk_sys) begin
        nvm_data <= mem[nvm_addr];
    end
endmodule
